// ### logic/spfm_pkg.sv
// Purpose: constants for the switch pin-function and strap block
// Assumes: 40 MHz sys_clk, APB register access, byte offsets below
// Notes: low-active pins are inverted at the pin boundary only
`default_nettype none
package spfm_pkg;
	localparam int GPIO_W     = 12;
	localparam int LANE_W     = 5;
	localparam int STRAP_W    = 4;
	localparam int SADDR_W    = 7;
	localparam int SYNC_W     = GPIO_W + 1 + 2 * STRAP_W;
	localparam int SYNC_FILL  = 2;

	localparam logic [7:0] OFF_ALTSEL = 8'h00;
	localparam logic [7:0] OFF_DIR    = 8'h04;
	localparam logic [7:0] OFF_DOUT   = 8'h08;
	localparam logic [7:0] OFF_DIN    = 8'h0c;
	localparam logic [7:0] OFF_PRST   = 8'h10;
	localparam logic [7:0] OFF_GPE    = 8'h14;
	localparam logic [7:0] OFF_STRAP  = 8'h18;
	localparam logic [7:0] OFF_LANE   = 8'h1c;
	localparam logic [7:0] OFF_IRQ    = 8'h20;

	localparam logic [GPIO_W-1:0] ALT_CAPABLE = 12'h69f;
	localparam logic [GPIO_W-1:0] ALT_OUTPUT  = 12'h683;
	localparam int PIN_PORT2_RST = 0;
	localparam int PIN_PORT4_RST = 1;
	localparam int PIN_EXP_IRQ0  = 2;
	localparam int PIN_GEN_EVENT = 7;
	localparam int PIN_PORT3_RST = 9;
	localparam int PIN_PORT5_RST = 10;

	// port reset control bits
	localparam int PRST_PORT2 = 0;
	localparam int PRST_PORT3 = 1;
	localparam int PRST_PORT4 = 2;
	localparam int PRST_PORT5 = 3;
	localparam logic [3:0] PRST_RESET = 4'hf;
	localparam logic [3:0] GPE_RESET  = 4'h0;
	localparam logic [LANE_W-1:0] LANE_RESET = 5'h1f;

	// strap register field positions
	localparam int STRAP_REF_POS = 0;
	localparam int STRAP_EEP_POS = 8;
	localparam int STRAP_SLV_POS = 16;
	localparam int STRAP_FB_POS  = 24;

	// fixed bits around the strapped address bits
	localparam logic [SADDR_W-1:0] EEP_ADDR_BASE = 7'h50;
	localparam logic [SADDR_W-1:0] SLV_ADDR_BASE = 7'h50;

	localparam int REF_LO_MHZ = 100;
	localparam int REF_HI_MHZ = 125;
	localparam int LINE_MHZ   = 2500;
	localparam logic [7:0] FB_DIV_LO = 8'(LINE_MHZ / REF_LO_MHZ);
	localparam logic [7:0] FB_DIV_HI = 8'(LINE_MHZ / REF_HI_MHZ);

	typedef enum logic [1:0] {
		ST_FILL  = 2'b00,
		ST_LATCH = 2'b01,
		ST_RUN   = 2'b10
	} spfm_strap_e;
endpackage
`default_nettype wire

// ### logic/spfm_sync_if.sv
// Purpose: carries raw pin levels to the synchroniser and back
// Assumes: single sys_clk domain on the sync side
// Notes: sync is only valid two edges after raw settles
`timescale 1ns/10ps
`default_nettype none
interface spfm_sync_if;
	logic [spfm_pkg::SYNC_W-1:0] raw;
	logic [spfm_pkg::SYNC_W-1:0] sync;
	modport src (output raw, input sync);
	modport dst (input raw, output sync);
endinterface
`default_nettype wire

// ### logic/spfm_sync.sv
// Purpose: two-flop synchroniser for every pin and strap input
// Assumes: inputs come from outside sys_clk domain
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module spfm_sync (
	input  wire logic   sys_clk,
	input  wire logic   resetn,
	spfm_sync_if.dst    port
);
	logic [spfm_pkg::SYNC_W-1:0] meta_q;
	logic [spfm_pkg::SYNC_W-1:0] sync_q;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= port.raw;
			sync_q <= meta_q;
		end
	end

	assign port.sync = sync_q;
endmodule
`default_nettype wire

// ### logic/spfm_top.sv
// Purpose: general purpose pin muxing and strap decoding
// Assumes: APB master on sys_clk, pins asynchronous to it
// Notes: one wait state on every APB access
`timescale 1ns/10ps
`default_nettype none
module spfm_top (
	input  wire logic                                sys_clk,
	input  wire logic                                resetn,
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [7:0]                          paddr,
	input  wire logic [31:0]                         pwdata,
	output logic      [31:0]                         prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	input  wire logic [spfm_pkg::GPIO_W-1:0]         gpioIn,
	output logic      [spfm_pkg::GPIO_W-1:0]         gpioOut,
	output logic      [spfm_pkg::GPIO_W-1:0]         gpioOe,
	input  wire logic                                refClockFreqSelect,
	input  wire logic [spfm_pkg::STRAP_W-1:0]        eepromBusAddrStrap,
	input  wire logic [spfm_pkg::STRAP_W-1:0]        slaveBusAddrStrap,
	output logic                                     refClk125Sel,
	output logic      [7:0]                          pllFbDiv,
	output logic      [spfm_pkg::SADDR_W-1:0]        eepromBusAddr,
	output logic      [spfm_pkg::SADDR_W-1:0]        slaveBusAddr,
	output logic                                     strapValid,
	input  wire logic                                probeValid,
	input  wire logic [spfm_pkg::SADDR_W-1:0]        probeAddr,
	output logic                                     probeHit,
	output logic      [2:0]                          expanderIrq,
	output logic      [spfm_pkg::LANE_W-1:0]         laneEnable
);
	localparam int GW = spfm_pkg::GPIO_W;
	localparam int SW = spfm_pkg::STRAP_W;
	localparam int AW = spfm_pkg::SADDR_W;

	function automatic logic isReg(input logic [7:0] addr, input logic [7:0] off);
		isReg = (addr == off);
	endfunction

	spfm_sync_if syncBus ();

	spfm_sync u_sync (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.port    (syncBus.dst)
	);

	assign syncBus.raw = {slaveBusAddrStrap, eepromBusAddrStrap, refClockFreqSelect, gpioIn};

	logic [GW-1:0] gpioSync;
	logic          refSelSync;
	logic [SW-1:0] eepStrapSync;
	logic [SW-1:0] slvStrapSync;
	assign gpioSync     = syncBus.sync[GW-1:0];
	assign refSelSync   = syncBus.sync[GW];
	assign eepStrapSync = syncBus.sync[GW+SW:GW+1];
	assign slvStrapSync = syncBus.sync[GW+2*SW:GW+SW+1];

	// software registers
	logic [GW-1:0]                 altSel_q;
	logic [GW-1:0]                 dir_q;
	logic [GW-1:0]                 dout_q;
	logic [3:0]                    prst_q;
	logic [3:0]                    gpeCtl_q;
	logic [spfm_pkg::LANE_W-1:0]   lane_q;

	// strap state
	spfm_pkg::spfm_strap_e         strapSt_q;
	logic [1:0]                    fillCnt_q;
	logic                          refSel_q;
	logic [7:0]                    fbDiv_q;
	logic [AW-1:0]                 eepAddr_q;
	logic [AW-1:0]                 slvAddr_q;
	logic                          strapValid_q;
	logic                          probeHit_q;

	// pin state
	logic [GW-1:0]                 gpioOut_q;
	logic [GW-1:0]                 gpioOe_q;
	logic [2:0]                    expIrq_q;
	logic                          gpe_q;
	logic [GW-1:0]                 altOn;
	logic [GW-1:0]                 altAssert;

	// bus state
	logic [31:0]                   prdata_q;
	logic                          pready_q;
	logic                          pslverr_q;
	logic [31:0]                   readData;
	logic                          regHit;
	logic                          access;
	logic                          answer;
	logic                          wrEn;

	assign access = psel & penable;
	assign answer = access & ~pready_q;
	assign wrEn   = access & pready_q & pwrite & regHit;

	always_comb begin
		readData = '0;
		regHit   = 1'b1;
		case (paddr)
			spfm_pkg::OFF_ALTSEL: readData = 32'(altSel_q);
			spfm_pkg::OFF_DIR:    readData = 32'(dir_q);
			spfm_pkg::OFF_DOUT:   readData = 32'(dout_q);
			spfm_pkg::OFF_DIN:    readData = 32'(gpioSync);
			spfm_pkg::OFF_PRST:   readData = 32'(prst_q);
			spfm_pkg::OFF_GPE:    readData = 32'(gpeCtl_q);
			spfm_pkg::OFF_LANE:   readData = 32'(lane_q);
			spfm_pkg::OFF_IRQ:    readData = 32'({gpe_q, expIrq_q});
			spfm_pkg::OFF_STRAP: begin
				readData[spfm_pkg::STRAP_REF_POS]               = refSel_q;
				readData[spfm_pkg::STRAP_EEP_POS +: AW]         = eepAddr_q;
				readData[spfm_pkg::STRAP_SLV_POS +: AW]         = slvAddr_q;
				readData[spfm_pkg::STRAP_FB_POS +: 8]           = fbDiv_q;
				readData[spfm_pkg::STRAP_REF_POS + 1]           = strapValid_q;
			end
			default: regHit = 1'b0;
		endcase
	end

	// apb answer one cycle into the access phase
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
		end else begin
			pready_q  <= answer;
			pslverr_q <= answer & ~regHit;
			prdata_q  <= (answer & ~pwrite) ? readData : '0;
		end
	end

	// alternate select bits only exist on capable pins
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			altSel_q <= '0;
			dir_q    <= '0;
			dout_q   <= '0;
		end else if (wrEn) begin
			if (isReg(paddr, spfm_pkg::OFF_ALTSEL))
				altSel_q <= pwdata[GW-1:0] & spfm_pkg::ALT_CAPABLE;
			if (isReg(paddr, spfm_pkg::OFF_DIR))
				dir_q <= pwdata[GW-1:0];
			if (isReg(paddr, spfm_pkg::OFF_DOUT))
				dout_q <= pwdata[GW-1:0];
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			prst_q   <= spfm_pkg::PRST_RESET;
			gpeCtl_q <= spfm_pkg::GPE_RESET;
			lane_q   <= spfm_pkg::LANE_RESET;
		end else if (wrEn) begin
			if (isReg(paddr, spfm_pkg::OFF_PRST))
				prst_q <= pwdata[3:0];
			if (isReg(paddr, spfm_pkg::OFF_GPE))
				gpeCtl_q <= pwdata[3:0];
			if (isReg(paddr, spfm_pkg::OFF_LANE))
				lane_q <= pwdata[spfm_pkg::LANE_W-1:0];
		end
	end

	// strap capture once the synchroniser has filled
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			strapSt_q    <= spfm_pkg::ST_FILL;
			fillCnt_q    <= '0;
			strapValid_q <= 1'b0;
		end else begin
			case (strapSt_q)
				spfm_pkg::ST_FILL: begin
					fillCnt_q <= fillCnt_q + 2'h1;
					if (fillCnt_q == 2'(spfm_pkg::SYNC_FILL - 1))
						strapSt_q <= spfm_pkg::ST_LATCH;
				end
				spfm_pkg::ST_LATCH: begin
					strapValid_q <= 1'b1;
					strapSt_q    <= spfm_pkg::ST_RUN;
				end
				spfm_pkg::ST_RUN: strapSt_q <= spfm_pkg::ST_RUN;
				default: strapSt_q <= spfm_pkg::ST_FILL;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			refSel_q  <= 1'b0;
			fbDiv_q   <= spfm_pkg::FB_DIV_LO;
			eepAddr_q <= spfm_pkg::EEP_ADDR_BASE;
			slvAddr_q <= spfm_pkg::SLV_ADDR_BASE;
		end else if (strapSt_q == spfm_pkg::ST_LATCH) begin
			refSel_q  <= refSelSync;
			fbDiv_q   <= refSelSync ? spfm_pkg::FB_DIV_HI : spfm_pkg::FB_DIV_LO;
			eepAddr_q <= {spfm_pkg::EEP_ADDR_BASE[6:5], eepStrapSync, spfm_pkg::EEP_ADDR_BASE[0]};
			slvAddr_q <= {spfm_pkg::SLV_ADDR_BASE[6], slvStrapSync[3], spfm_pkg::SLV_ADDR_BASE[4],
				slvStrapSync[2:0], spfm_pkg::SLV_ADDR_BASE[0]};
		end
	end

	// slave bus address compare, blocked until straps are known
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			probeHit_q <= 1'b0;
		else
			probeHit_q <= probeValid & strapValid_q & (probeAddr == slvAddr_q);
	end

	// expander interrupts and general purpose event
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			expIrq_q <= '0;
			gpe_q    <= 1'b0;
		end else begin
			expIrq_q <= altOn[spfm_pkg::PIN_EXP_IRQ0 +: 3] & ~gpioSync[spfm_pkg::PIN_EXP_IRQ0 +: 3];
			gpe_q    <= gpeCtl_q[0] | (|(expIrq_q & gpeCtl_q[3:1]));
		end
	end

	always_comb begin
		altAssert = '0;
		altAssert[spfm_pkg::PIN_PORT2_RST] = prst_q[spfm_pkg::PRST_PORT2];
		altAssert[spfm_pkg::PIN_PORT4_RST] = prst_q[spfm_pkg::PRST_PORT4];
		altAssert[spfm_pkg::PIN_PORT3_RST] = prst_q[spfm_pkg::PRST_PORT3];
		altAssert[spfm_pkg::PIN_PORT5_RST] = prst_q[spfm_pkg::PRST_PORT5];
		altAssert[spfm_pkg::PIN_GEN_EVENT] = gpe_q;
	end

	// one function per pin: alternate source or plain data and direction
	for (genvar i = 0; i < GW; i++) begin : g_pin
		assign altOn[i] = altSel_q[i] & spfm_pkg::ALT_CAPABLE[i];

		always_ff @(posedge sys_clk or negedge resetn) begin
			if (!resetn) begin
				gpioOe_q[i]  <= 1'b0;
				gpioOut_q[i] <= 1'b0;
			end else if (altOn[i] && spfm_pkg::ALT_OUTPUT[i]) begin
				gpioOe_q[i]  <= 1'b1;
				gpioOut_q[i] <= ~altAssert[i];
			end else if (altOn[i]) begin
				gpioOe_q[i]  <= 1'b0;
				gpioOut_q[i] <= 1'b0;
			end else begin
				gpioOe_q[i]  <= dir_q[i];
				gpioOut_q[i] <= dout_q[i];
			end
		end
	end

	assign prdata        = prdata_q;
	assign pready        = pready_q;
	assign pslverr       = pslverr_q;
	assign gpioOut       = gpioOut_q;
	assign gpioOe        = gpioOe_q;
	assign refClk125Sel  = refSel_q;
	assign pllFbDiv      = fbDiv_q;
	assign eepromBusAddr = eepAddr_q;
	assign slaveBusAddr  = slvAddr_q;
	assign strapValid    = strapValid_q;
	assign probeHit      = probeHit_q;
	assign expanderIrq   = expIrq_q;
	assign laneEnable    = lane_q;
endmodule
`default_nettype wire

// ### tb/spfm_board.sv
// Purpose: board side of the pins, with pull-ups and expander lines
// Assumes: expanders pull their open-drain lines low
// Notes: undriven pins show extIn, except pins 2 to 4, which show the expander lines
`timescale 1ns/10ps
`default_nettype none
module spfm_board (
	input  wire logic [11:0] gpioOut,
	input  wire logic [11:0] gpioOe,
	input  wire logic [11:0] extIn,
	input  wire logic [2:0]  irqAssert,
	output logic      [11:0] gpioIn
);
	logic [11:0] idle;
	// pulled up unless an expander asserts low
	assign idle = {extIn[11:5], ~irqAssert, extIn[1:0]};
	assign gpioIn = (gpioOe & gpioOut) | (~gpioOe & idle);
endmodule
`default_nettype wire

// ### tb/spfm_checker.sv
// Purpose: port checks for the pin mux block
// Assumes: bound to spfm_top
// Notes: one clock domain
`timescale 1ns/10ps
`default_nettype none
module spfm_checker (
	input wire logic        sys_clk,
	input wire logic        resetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [11:0] gpioIn,
	input wire logic [11:0] gpioOe,
	input wire logic        refClockFreqSelect,
	input wire logic [3:0]  eepromBusAddrStrap,
	input wire logic [3:0]  slaveBusAddrStrap,
	input wire logic        refClk125Sel,
	input wire logic [7:0]  pllFbDiv,
	input wire logic [6:0]  eepromBusAddr,
	input wire logic [6:0]  slaveBusAddr,
	input wire logic        strapValid,
	input wire logic        probeValid,
	input wire logic [6:0]  probeAddr,
	input wire logic        probeHit,
	input wire logic [2:0]  expanderIrq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	sequence s_release;
		$rose(resetn);
	endsequence
	sequence s_access;
		psel && penable && !$past(penable);
	endsequence
	property p_wait; s_access |-> !pready ##1 pready; endproperty
	a_wait: assert property (p_wait) else $error("bad wait");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("stray error");
	property p_oeReset; s_release |-> (gpioOe == 12'h0)[*3]; endproperty
	a_oeReset: assert property (p_oeReset) else $error("pin driven");
	property p_latch; s_release |-> !strapValid[*3] ##1 strapValid; endproperty
	a_latch: assert property (p_latch) else $error("latch time");
	property p_ref; strapValid |-> refClk125Sel == refClockFreqSelect && pllFbDiv == (refClk125Sel ? 8'h14 : 8'h19);
	endproperty
	a_ref: assert property (p_ref) else $error("ref clock");
	property p_eep; strapValid |-> eepromBusAddr[4:1] == eepromBusAddrStrap; endproperty
	a_eep: assert property (p_eep) else $error("eeprom addr");
	property p_slv; strapValid |-> {slaveBusAddr[5], slaveBusAddr[3:1]} == slaveBusAddrStrap; endproperty
	a_slv: assert property (p_slv) else $error("slave addr");
	property p_hit; probeValid && strapValid && probeAddr == slaveBusAddr |=> probeHit; endproperty
	a_hit: assert property (p_hit) else $error("no hit");
	property p_miss; !(probeValid && strapValid && probeAddr == slaveBusAddr) |=> !probeHit; endproperty
	a_miss: assert property (p_miss) else $error("stray hit");
	property p_irq; (expanderIrq & $past(gpioIn[4:2], 3)) == 3'h0; endproperty
	a_irq: assert property (p_irq) else $error("irq level");
endmodule
bind spfm_top spfm_checker u_spfm_checker (.sys_clk, .resetn, .psel, .penable, .pready, .pslverr, .gpioIn,
	.gpioOe, .refClockFreqSelect, .eepromBusAddrStrap, .slaveBusAddrStrap, .refClk125Sel, .pllFbDiv,
	.eepromBusAddr, .slaveBusAddr, .strapValid, .probeValid, .probeAddr, .probeHit, .expanderIrq);
`default_nettype wire

// ### tb/spfm_top_tb.sv
// Purpose: self-checking bench for the pin mux block
// Assumes: APB master here, board model on the pins
// Notes: answers are checked by a monitor from a queue
`timescale 1ns/10ps
`default_nettype none
module spfm_top_tb;
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, probeValid = 1'b0, refSel = 1'b0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, refClk125Sel, strapValid, probeHit;
	logic [11:0] gpioIn, gpioOut, gpioOe, extIn = 12'h0;
	logic [3:0]  eepStrap = 4'h0, slvStrap = 4'h0;
	logic [7:0]  pllFbDiv;
	logic [6:0]  eepromBusAddr, slaveBusAddr, probeAddr = 7'h0;
	logic [2:0]  expanderIrq, irqAssert = 3'h0;
	logic [4:0]  laneEnable;
	logic [32:0] expQ[$];
	int          miscompares = 0, comparisons = 0;
	always #12.5 sys_clk = ~sys_clk;
	spfm_top u_spfm_top (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .gpioIn, .gpioOut, .gpioOe, .refClockFreqSelect(refSel), .eepromBusAddrStrap(eepStrap),
		.slaveBusAddrStrap(slvStrap), .refClk125Sel, .pllFbDiv, .eepromBusAddr, .slaveBusAddr, .strapValid,
		.probeValid, .probeAddr, .probeHit, .expanderIrq, .laneEnable);
	spfm_board u_spfm_board (.gpioOut, .gpioOe, .extIn, .irqAssert, .gpioIn);
	task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic report_and_stop;
		if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
		expQ.push_back(e);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d, 33'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0, {1'b0, e});
	endtask
	always @(posedge sys_clk) begin
		if (psel && penable && pready === 1'b1) chk("apb", expQ.pop_front(), {pslverr, prdata});
	end
	initial begin
		#500000;
		miscompares++;
		report_and_stop();
	end
	initial begin
		logic [7:0]  fb;
		logic [6:0]  es, ss;
		logic [3:0]  p, g;
		logic [2:0]  q;
		logic [11:0] d, o, x, e;
		void'($urandom(32'h02f7db7e));
		for (int r = 0; r < 2; r++) begin
			resetn <= 1'b0;
			refSel <= r[0];
			eepStrap <= 4'($urandom());
			slvStrap <= 4'($urandom());
			repeat (10) @(posedge sys_clk);
			resetn <= 1'b1;
			for (int n = 0; n < 20 && strapValid !== 1'b1; n++) @(posedge sys_clk);
			fb = r[0] ? 8'h14 : 8'h19;
			es = {2'b10, eepStrap, 1'b0};
			ss = {1'b1, slvStrap[3], 1'b1, slvStrap[2:0], 1'b0};
			chk("pllFbDiv", {r[0], fb}, {refClk125Sel, pllFbDiv});
			chk("busAddr", {es, ss}, {eepromBusAddr, slaveBusAddr});
			rd(spfm_pkg::OFF_STRAP, {fb, 1'b0, ss, 1'b0, es, 6'h0, 1'b1, r[0]});
		end
		rd(spfm_pkg::OFF_ALTSEL, 32'h0);
		rd(spfm_pkg::OFF_DIR, 32'h0);
		rd(spfm_pkg::OFF_PRST, 32'hf);
		rd(spfm_pkg::OFF_LANE, 32'h1f);
		apb(8'h24, 1'b1, $urandom(), {1'b1, 32'h0});
		apb(8'h24, 1'b0, 32'h0, {1'b1, 32'h0});
		wr(spfm_pkg::OFF_ALTSEL, 32'hffffffff);
		rd(spfm_pkg::OFF_ALTSEL, 32'h69f);
		for (int i = 0; i < 4; i++) begin
			p = 4'($urandom());
			g = 4'($urandom());
			q = 3'($urandom());
			irqAssert <= q;
			wr(spfm_pkg::OFF_PRST, {28'h0, p});
			wr(spfm_pkg::OFF_GPE, {28'h0, g});
			repeat (4) @(posedge sys_clk);
			e = {1'b0, ~p[3], ~p[1], 1'b0, ~(g[0] | |(g[3:1] & q)), 5'h0, ~p[2], ~p[0]};
			chk("altPins", e, gpioOut & 12'h683);
			chk("gpioOe", 12'h683, gpioOe);
			chk("expanderIrq", q, expanderIrq);
			rd(spfm_pkg::OFF_IRQ, {28'h0, ~e[7], q});
		end
		irqAssert <= 3'h0;
		wr(spfm_pkg::OFF_ALTSEL, 32'h0);
		wr(spfm_pkg::OFF_DIN, 32'hfff);
		for (int i = 0; i < 4; i++) begin
			d = 12'($urandom());
			o = 12'($urandom());
			x = 12'($urandom());
			extIn <= x;
			wr(spfm_pkg::OFF_DIR, {20'h0, d});
			wr(spfm_pkg::OFF_DOUT, {20'h0, o});
			repeat (4) @(posedge sys_clk);
			chk("gpioOe", d, gpioOe);
			chk("gpioOut", o & d, gpioOut & d);
			rd(spfm_pkg::OFF_DIN, {20'h0, (d & o) | (~d & {x[11:5], 3'h7, x[1:0]})});
		end
		wr(spfm_pkg::OFF_LANE, {27'h0, d[4:0]});
		rd(spfm_pkg::OFF_LANE, {27'h0, d[4:0]});
		chk("laneEnable", d[4:0], laneEnable);
		for (int m = 0; m < 2; m++) begin
			probeValid <= 1'b1;
			probeAddr <= ss ^ 7'(m);
			@(posedge sys_clk);
			probeValid <= 1'b0;
			@(posedge sys_clk);
			chk("probeHit", m == 0, probeHit);
		end
		chk("pending", 33'h0, 33'(expQ.size()));
		report_and_stop();
	end
endmodule
`default_nettype wire
